/* File: hw/tfr_defines.svh */
// register offsets, reset values and fixed counts of the ring protection sublayer
// assumes inclusion by bare name from each design file
`ifndef TFR_DEFINES_SVH
`define TFR_DEFINES_SVH
`define TFR_OFF_CTRL 8'h00
`define TFR_OFF_SLOT 8'h04
`define TFR_OFF_STAT 8'h08
`define TFR_OFF_APS 8'h0c
`define TFR_CTRL_REPORT_BIT 0
`define TFR_CTRL_RST 1'b0
`define TFR_SLOT_RST 16'h5555
`define TFR_APS_FRAMES 2'd3
`define TFR_PROT_SLOTS 8
`define TFR_AIS_BYTE 8'hff
`define TFR_UNEQ_BYTE 8'h00
`define TFR_STAT_FAIL_BIT 0
`define TFR_STAT_DEGRADE_BIT 1
`define TFR_STAT_CAUSE_BIT 2
`define TFR_STAT_TRAIL_BIT 3
`endif

/* File: hw/tfr_pkg.sv */
// types shared by the ring protection sublayer modules
// assumes nothing beyond a SystemVerilog compiler
package tfr_pkg;
   typedef enum logic [2:0] {KIND_OTHER, KIND_PTR, KIND_PAYLOAD, KIND_K1, KIND_K2} tfr_kind_t;
   // one byte of the frame with its position; valid is the byte clock
   typedef struct packed {
      logic valid;
      logic frameStart;
      tfr_kind_t kind;
      logic [3:0] slot;
      logic [7:0] data;
   } tfr_beat_t;
   typedef enum logic [1:0] {SLOT_CARRY, SLOT_UNEQUIPPED, SLOT_SQUELCH, SLOT_SQUELCH_ALT} tfr_slot_mode_t;
   typedef struct packed {
      logic [7:0] k1Hold;
      logic [15:0] lastWord;
      logic [1:0] matchCnt;
      logic [15:0] accepted;
   } tfr_aps_state_t;
   typedef struct packed {
      logic reportEnable;
      logic [15:0] slotMode;
      logic [31:0] rdData;
      tfr_beat_t lineOut;
      tfr_beat_t workOut;
      tfr_beat_t protOut;
      tfr_beat_t ttSrcOut;
      tfr_beat_t ttSnkOut;
      logic serverFail;
      logic serverDegrade;
      logic trailFail;
      logic failCause;
   } tfr_top_state_t;
endpackage

/* File: hw/tfr_aps_filter.sv */
// three-frame persistence filter for the received K1/K2 switching word
// assumes one K1 and one K2 byte per frame on the incoming beat
`timescale 1ns/1ps
`default_nettype none
`include "tfr_defines.svh"
module tfr_aps_filter (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // incoming line beat
   input wire tfr_pkg::tfr_beat_t inBeat,
   // accepted word
   output logic [15:0] acceptedWord
);
   tfr_pkg::tfr_aps_state_t st_reg;
   tfr_pkg::tfr_aps_state_t st_next;
   logic [15:0] word;

   always_comb begin
      st_next = st_reg;
      word = {st_reg.k1Hold, inBeat.data};
      if (clkEn && inBeat.valid) begin
         if (inBeat.kind == tfr_pkg::KIND_K1) begin
            st_next.k1Hold = inBeat.data;
         end
         if (inBeat.kind == tfr_pkg::KIND_K2) begin
            if (word == st_reg.lastWord) begin
               if (st_reg.matchCnt != `TFR_APS_FRAMES) begin
                  st_next.matchCnt = st_reg.matchCnt + 2'd1;
               end
            end else begin
               st_next.matchCnt = 2'd1;
            end
            st_next.lastWord = word;
            // earlier value is held until the new one persists
            if (st_next.matchCnt == `TFR_APS_FRAMES) begin
               st_next.accepted = word;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign acceptedWord = st_reg.accepted;

   property p_accept_persist;
      @(posedge core_clk) disable iff (sys_rst)
         (st_reg.accepted != $past(st_reg.accepted)) |-> (st_reg.matchCnt == 2'd3) && (st_reg.lastWord == st_reg.accepted);
   endproperty
   a_accept_persist: assert property (p_accept_persist) else $error("aps word accepted without three equal frames");

   property p_mismatch_restart;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && inBeat.valid && inBeat.kind == tfr_pkg::KIND_K2 && {st_reg.k1Hold, inBeat.data} != st_reg.lastWord)
         |=> (st_reg.matchCnt == 2'd1) && (st_reg.accepted == $past(st_reg.accepted));
   endproperty
   a_mismatch_restart: assert property (p_mismatch_restart) else $error("aps mismatch did not restart count");
endmodule // tfr_aps_filter
`default_nettype wire

/* File: hw/tfr_slot_insert.sv */
// protection timeslot content selection: carry, unequipped or all-ones squelch
// assumes the timing beat carries a valid pointer in its pointer bytes
`timescale 1ns/1ps
`default_nettype none
`include "tfr_defines.svh"
module tfr_slot_insert #(
   parameter int PROT_SLOTS = `TFR_PROT_SLOTS
) (
   // position and data
   input wire tfr_pkg::tfr_beat_t timing,
   input wire logic [7:0] protData,
   input wire logic [2*PROT_SLOTS-1:0] slotMode,
   // chosen byte
   output logic [7:0] outData
);
   logic [PROT_SLOTS-1:0] squelchMask;
   logic [PROT_SLOTS-1:0] unequipMask;

   genvar i;
   generate
      for (i = 0; i < PROT_SLOTS; i++) begin : g_mode
         assign squelchMask[i] = slotMode[2*i+1];
         assign unequipMask[i] = (slotMode[2*i+1:2*i] == tfr_pkg::SLOT_UNEQUIPPED);
      end
   endgenerate

   always_comb begin
      outData = protData;
      if (timing.kind == tfr_pkg::KIND_PTR || timing.kind == tfr_pkg::KIND_PAYLOAD) begin
         if (squelchMask[timing.slot[2:0]]) begin
            outData = `TFR_AIS_BYTE;
         end else if (unequipMask[timing.slot[2:0]]) begin
            // the local pointer keeps the unused slot valid to the far end
            outData = (timing.kind == tfr_pkg::KIND_PTR) ? timing.data : `TFR_UNEQ_BYTE;
         end
      end
   end
endmodule // tfr_slot_insert
`default_nettype wire

/* File: hw/tfr_protection.sv */
// Notes on behaviour
// - unused protection slot gets unequipped content with a valid pointer
// - protection slot that would be misconnected is squelched to all ones
// - trail termination source passes data, clock and frame start unchanged
// - trail fail is reported for the working capacity when no connection exists
// - fail report cause is server fail in and report enable
// - source puts working group in slots 1 to 8, protection in 9 to 16
// - source writes the switching word into K1 and K2
// - sink splits slots 1 to 8 to working, 9 to 16 to protection
// - sink extracts the sixteen bit word, K1 then K2, every frame
// - sink accepts a new word only after three identical consecutive frames
// - working line output is routed from its own working tributary input
//
// top of the two-fibre shared ring protection sublayer
// assumes a frame timing beat from the neighbouring section functions, synchronous inputs
`timescale 1ns/1ps
`default_nettype none
`include "tfr_defines.svh"
module tfr_protection (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // adaptation source
   input wire tfr_pkg::tfr_beat_t srcTiming,
   input wire logic [7:0] workingGroupData,
   input wire logic [7:0] protectionGroupData,
   input wire logic [15:0] ringSwitchWord,
   output tfr_pkg::tfr_beat_t lineOut,
   // adaptation sink
   input wire tfr_pkg::tfr_beat_t lineIn,
   input wire logic trailFailIn,
   input wire logic trailDegradeIn,
   output tfr_pkg::tfr_beat_t workingGroupOut,
   output tfr_pkg::tfr_beat_t protectionGroupOut,
   output logic [15:0] ringSwitchWordOut,
   output logic serverFailAction,
   output logic serverDegradeAction,
   // trail termination source
   input wire tfr_pkg::tfr_beat_t ttSrcIn,
   output tfr_pkg::tfr_beat_t ttSrcOut,
   // trail termination sink
   input wire tfr_pkg::tfr_beat_t ttSnkIn,
   input wire logic serverFailIn,
   output tfr_pkg::tfr_beat_t ttSnkOut,
   output logic trailFailAction,
   output logic failReportCause
);
   tfr_pkg::tfr_top_state_t st_reg;
   tfr_pkg::tfr_top_state_t st_next;
   logic [7:0] protChosen;
   logic [15:0] apsAccepted;
   logic carried;
   logic lineCarried;

   // ------------------------------------------------------------
   // protection slot insertion and switching word filter
   // ------------------------------------------------------------
   tfr_slot_insert #(
      .PROT_SLOTS(`TFR_PROT_SLOTS)
   ) u_insert (
      .timing(srcTiming),
      .protData(protectionGroupData),
      .slotMode(st_reg.slotMode),
      .outData(protChosen)
   );

   tfr_aps_filter u_aps (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .inBeat(lineIn),
      .acceptedWord(apsAccepted)
   );

   assign carried = (srcTiming.kind == tfr_pkg::KIND_PTR) || (srcTiming.kind == tfr_pkg::KIND_PAYLOAD);
   assign lineCarried = (lineIn.kind == tfr_pkg::KIND_PTR) || (lineIn.kind == tfr_pkg::KIND_PAYLOAD);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (clkEn) begin
         // register port; read data live for one cycle only
         st_next.rdData = '0;
         if (regWr) begin
            case (regAddr)
               `TFR_OFF_CTRL: st_next.reportEnable = regWrData[`TFR_CTRL_REPORT_BIT];
               `TFR_OFF_SLOT: st_next.slotMode = regWrData[15:0];
               default: st_next.reportEnable = st_reg.reportEnable;
            endcase
         end
         if (regRd) begin
            case (regAddr)
               `TFR_OFF_CTRL: st_next.rdData = {31'h0, st_reg.reportEnable};
               `TFR_OFF_SLOT: st_next.rdData = {16'h0, st_reg.slotMode};
               `TFR_OFF_STAT: st_next.rdData = {28'h0, st_reg.trailFail, st_reg.failCause,
                                                st_reg.serverDegrade, st_reg.serverFail};
               `TFR_OFF_APS: st_next.rdData = {16'h0, apsAccepted};
               default: st_next.rdData = '0;
            endcase
         end

         // adaptation source: timing beat gives position, content chosen per slot
         st_next.lineOut = srcTiming;
         if (carried) begin
            if (!srcTiming.slot[3]) begin
               st_next.lineOut.data = workingGroupData;
            end else begin
               st_next.lineOut.data = protChosen;
            end
         end else if (srcTiming.kind == tfr_pkg::KIND_K1) begin
            st_next.lineOut.data = ringSwitchWord[15:8];
         end else if (srcTiming.kind == tfr_pkg::KIND_K2) begin
            st_next.lineOut.data = ringSwitchWord[7:0];
         end

         // adaptation sink: each group sees only its own slots
         st_next.workOut = lineIn;
         st_next.protOut = lineIn;
         st_next.workOut.valid = lineIn.valid && lineCarried && !lineIn.slot[3];
         st_next.protOut.valid = lineIn.valid && lineCarried && lineIn.slot[3];
         st_next.serverFail = trailFailIn;
         st_next.serverDegrade = trailDegradeIn;

         // trail termination source: plain pass
         st_next.ttSrcOut = ttSrcIn;

         // trail termination sink: fail of the protected working trail
         st_next.ttSnkOut = ttSnkIn;
         st_next.trailFail = serverFailIn;
         st_next.failCause = serverFailIn && st_reg.reportEnable;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.reportEnable <= `TFR_CTRL_RST;
         st_reg.slotMode <= `TFR_SLOT_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign regRdData = st_reg.rdData;
   assign lineOut = st_reg.lineOut;
   assign workingGroupOut = st_reg.workOut;
   assign protectionGroupOut = st_reg.protOut;
   // filter output already comes from its own flip-flop
   assign ringSwitchWordOut = apsAccepted;
   assign serverFailAction = st_reg.serverFail;
   assign serverDegradeAction = st_reg.serverDegrade;
   assign ttSrcOut = st_reg.ttSrcOut;
   assign ttSnkOut = st_reg.ttSnkOut;
   assign trailFailAction = st_reg.trailFail;
   assign failReportCause = st_reg.failCause;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_unequipped;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && srcTiming.kind == tfr_pkg::KIND_PAYLOAD && srcTiming.slot[3]
          && st_reg.slotMode[{srcTiming.slot[2:0], 1'b0} +: 2] == tfr_pkg::SLOT_UNEQUIPPED)
         |=> (lineOut.data == 8'h00);
   endproperty
   a_unequipped: assert property (p_unequipped) else $error("unused protection slot not unequipped");

   property p_unequipped_ptr;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && srcTiming.kind == tfr_pkg::KIND_PTR && srcTiming.slot[3]
          && st_reg.slotMode[{srcTiming.slot[2:0], 1'b0} +: 2] == tfr_pkg::SLOT_UNEQUIPPED)
         |=> (lineOut.data == $past(srcTiming.data));
   endproperty
   a_unequipped_ptr: assert property (p_unequipped_ptr) else $error("unequipped slot lost its pointer");

   property p_squelch;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && carried && srcTiming.slot[3] && st_reg.slotMode[{srcTiming.slot[2:0], 1'b1}])
         |=> (lineOut.data == 8'hff);
   endproperty
   a_squelch: assert property (p_squelch) else $error("misconnected slot not squelched");

   property p_tt_pass;
      @(posedge core_clk) disable iff (sys_rst)
         clkEn |=> (ttSrcOut == $past(ttSrcIn));
   endproperty
   a_tt_pass: assert property (p_tt_pass) else $error("trail source altered its signal");

   property p_cause;
      @(posedge core_clk) disable iff (sys_rst)
         clkEn |=> (failReportCause == ($past(serverFailIn) && $past(st_reg.reportEnable)));
   endproperty
   a_cause: assert property (p_cause) else $error("fail report cause wrong");

   property p_working_slots;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && srcTiming.kind == tfr_pkg::KIND_PAYLOAD && !srcTiming.slot[3])
         |=> (lineOut.data == $past(workingGroupData)) && (lineOut.slot == $past(srcTiming.slot));
   endproperty
   a_working_slots: assert property (p_working_slots) else $error("working byte not in slots 1 to 8");

   property p_k_bytes;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && srcTiming.kind == tfr_pkg::KIND_K1) ##1 (clkEn && srcTiming.kind == tfr_pkg::KIND_K2)
         |=> (lineOut.data == $past(ringSwitchWord[7:0])) && ($past(lineOut.data) == $past(ringSwitchWord[15:8], 2));
   endproperty
   a_k_bytes: assert property (p_k_bytes) else $error("switching word not in K1 K2");

   property p_split;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && lineIn.valid && lineCarried)
         |=> (workingGroupOut.valid != protectionGroupOut.valid) && (protectionGroupOut.valid == $past(lineIn.slot[3]));
   endproperty
   a_split: assert property (p_split) else $error("sink split wrong group");

   property p_server_follow;
      @(posedge core_clk) disable iff (sys_rst)
         clkEn |=> (serverFailAction == $past(trailFailIn)) && (serverDegradeAction == $past(trailDegradeIn));
   endproperty
   a_server_follow: assert property (p_server_follow) else $error("server actions do not follow trail");

   property p_trail_fail;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && serverFailIn) |=> trailFailAction;
   endproperty
   a_trail_fail: assert property (p_trail_fail) else $error("trail fail not raised");

   property p_read_once;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && !regRd) |=> (regRdData == 32'h0);
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

   // a frozen block must not drift, or a paused stream would resume misaligned
   property p_freeze;
      @(posedge core_clk) disable iff (sys_rst)
         !clkEn |=> $stable(st_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

   property p_carry;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && carried && srcTiming.slot[3]
          && st_reg.slotMode[{srcTiming.slot[2:0], 1'b0} +: 2] == tfr_pkg::SLOT_CARRY)
         |=> (lineOut.data == $past(protectionGroupData));
   endproperty
   a_carry: assert property (p_carry) else $error("protection byte not in slots 9 to 16");

   property p_src_position;
      @(posedge core_clk) disable iff (sys_rst)
         clkEn |=> (lineOut.valid == $past(srcTiming.valid)) && (lineOut.kind == $past(srcTiming.kind))
            && (lineOut.frameStart == $past(srcTiming.frameStart));
   endproperty
   a_src_position: assert property (p_src_position) else $error("line beat lost its position");

   property p_sink_data;
      @(posedge core_clk) disable iff (sys_rst)
         clkEn |=> (workingGroupOut.data == $past(lineIn.data)) && (protectionGroupOut.slot == $past(lineIn.slot));
   endproperty
   a_sink_data: assert property (p_sink_data) else $error("sink group altered the line byte");

   property p_k_outside;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && !lineCarried) |=> !workingGroupOut.valid && !protectionGroupOut.valid;
   endproperty
   a_k_outside: assert property (p_k_outside) else $error("overhead byte reached a group");

   property p_trail_clear;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && !serverFailIn) |=> !trailFailAction;
   endproperty
   a_trail_clear: assert property (p_trail_clear) else $error("trail fail held without server fail");

   property p_aps_read;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && regRd && regAddr == `TFR_OFF_APS) |=> (regRdData == {16'h0, $past(apsAccepted)});
   endproperty
   a_aps_read: assert property (p_aps_read) else $error("switching word read back wrong");

   property p_status_read;
      @(posedge core_clk) disable iff (sys_rst)
         (clkEn && regRd && regAddr == `TFR_OFF_STAT)
         |=> (regRdData[3:0] == $past({trailFailAction, failReportCause, serverDegradeAction, serverFailAction}));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read disagrees with outputs");
endmodule // tfr_protection
`default_nettype wire

/* File: tb/tfr_line_partner.sv */
// neighbour section model: sends one line frame (K1, K2, sixteen payload slots) per request
// assumes requests only while not busy, synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module tfr_line_partner (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // frame request
   input wire logic sendReq,
   input wire logic [15:0] word,
   input wire logic [7:0] seed,
   // line stream
   output tfr_pkg::tfr_beat_t lineIn,
   output logic busy
);
   int pos;
   logic [15:0] w;
   logic [7:0] s;
   assign busy = (pos >= 0);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pos <= -1;
         lineIn <= '0;
      end else if (pos < 0) begin
         // no byte clock between frames; data toggles so a stale byte never looks held
         lineIn.valid <= 1'b0;
         lineIn.frameStart <= 1'b0;
         lineIn.data <= ~lineIn.data;
         if (sendReq) begin
            pos <= 0;
            w <= word;
            s <= seed;
         end
      end else begin
         lineIn.valid <= 1'b1;
         lineIn.frameStart <= (pos == 0);
         lineIn.kind <= pos == 0 ? tfr_pkg::KIND_K1 : pos == 1 ? tfr_pkg::KIND_K2 : tfr_pkg::KIND_PAYLOAD;
         lineIn.slot <= pos < 2 ? 4'h0 : 4'(pos - 2);
         lineIn.data <= pos == 0 ? w[15:8] : pos == 1 ? w[7:0] : s + 8'(pos - 2);
         pos <= pos == 17 ? -1 : pos + 1;
      end
   end
endmodule // tfr_line_partner
`default_nettype wire

/* File: tb/tfr_protection_test.sv */
// self-checking bench of the ring protection sublayer
// assumes the design files and the line partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tfr_defines.svh"
module tfr_protection_test;
   logic core_clk, sys_rst, clkEn, regWr, regRd, serverFailIn, trailFailIn, trailDegradeIn, sendReq, busy, rdSeen;
   logic [7:0] regAddr, workingGroupData, protectionGroupData, seed;
   logic [31:0] regWrData, regRdData;
   logic [15:0] ringSwitchWord, ringSwitchWordOut, slotVal, pWord;
   tfr_pkg::tfr_beat_t srcTiming, lineOut, lineIn, workingGroupOut, protectionGroupOut, ttSrcIn, ttSrcOut, ttSnkOut;
   logic serverFailAction, serverDegradeAction, trailFailAction, failReportCause;
   logic [31:0] qLine[$], qWork[$], qProt[$], qTt[$], qTs[$], qRd[$];
   int badCount, nChecks;
   tfr_protection tfr_protection_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcTiming(srcTiming),
      .workingGroupData(workingGroupData), .protectionGroupData(protectionGroupData),
      .ringSwitchWord(ringSwitchWord), .lineOut(lineOut), .lineIn(lineIn), .trailFailIn(trailFailIn),
      .trailDegradeIn(trailDegradeIn), .workingGroupOut(workingGroupOut), .protectionGroupOut(protectionGroupOut),
      .ringSwitchWordOut(ringSwitchWordOut), .serverFailAction(serverFailAction),
      .serverDegradeAction(serverDegradeAction), .ttSrcIn(ttSrcIn), .ttSrcOut(ttSrcOut), .ttSnkIn(ttSrcIn),
      .serverFailIn(serverFailIn), .ttSnkOut(ttSnkOut), .trailFailAction(trailFailAction),
      .failReportCause(failReportCause));
   tfr_line_partner tfr_line_partner_i (.core_clk(core_clk), .sys_rst(sys_rst), .sendReq(sendReq), .word(pWord),
      .seed(seed), .lineIn(lineIn), .busy(busy));
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a result with no note behind it is a mismatch too
   task automatic take(ref logic [31:0] q[$], input logic [31:0] seen);
      if (q.size() == 0)
         check(seen, ~seen);
      else
         check(seen, q.pop_front());
   endtask
   task automatic finalReport;
      if (badCount == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // outputs are registered, so the falling edge sees them settled
   always @(negedge core_clk) begin
      if (sys_rst === 1'b0) begin
         if (lineOut.valid === 1'b1) take(qLine, 32'(lineOut));
         if (workingGroupOut.valid === 1'b1) take(qWork, 32'(workingGroupOut));
         if (protectionGroupOut.valid === 1'b1) take(qProt, 32'(protectionGroupOut));
         if (ttSrcOut.valid === 1'b1) take(qTt, 32'(ttSrcOut));
         if (ttSnkOut.valid === 1'b1) take(qTs, 32'(ttSnkOut));
         if (rdSeen === 1'b1) take(qRd, regRdData);
         rdSeen = regRd;
      end
   end
   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic regRead(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      qRd.push_back(e);
      @(posedge core_clk);
      regRd <= 1'b0;
   endtask
   task automatic srcBeat(input tfr_pkg::tfr_kind_t k, input logic [3:0] sl);
      tfr_pkg::tfr_beat_t b, t;
      logic [1:0] m;
      logic [7:0] wd, pd;
      wd = 8'($urandom);
      pd = 8'($urandom);
      t = 17'($urandom);
      t.valid = 1'b1;
      t.kind = tfr_pkg::KIND_PAYLOAD;
      m = slotVal[{sl[2:0], 1'b0} +: 2];
      b = '{1'b1, k == tfr_pkg::KIND_K1, k, sl, 8'($urandom)};
      @(posedge core_clk);
      srcTiming <= b;
      workingGroupData <= wd;
      protectionGroupData <= pd;
      ttSrcIn <= t;
      qTt.push_back(32'(t));
      qTs.push_back(32'(t));
      if (k == tfr_pkg::KIND_K1) b.data = ringSwitchWord[15:8];
      else if (k == tfr_pkg::KIND_K2) b.data = ringSwitchWord[7:0];
      else if (k != tfr_pkg::KIND_OTHER && !sl[3]) b.data = wd;
      else if (k != tfr_pkg::KIND_OTHER && m == 2'd0) b.data = pd;
      else if (k == tfr_pkg::KIND_PAYLOAD && m == 2'd1) b.data = 8'h00;
      else if (k != tfr_pkg::KIND_OTHER && m[1]) b.data = 8'hff;
      qLine.push_back(32'(b));
   endtask
   // one line frame from the partner; groups are predicted from the seed
   task automatic sendFrame(input logic [15:0] w);
      int i;
      @(posedge core_clk);
      sendReq <= 1'b1;
      pWord <= w;
      seed <= 8'($urandom);
      @(posedge core_clk);
      sendReq <= 1'b0;
      for (i = 0; i < 16; i++) begin
         if (i < 8) qWork.push_back(32'({1'b1, 1'b0, tfr_pkg::KIND_PAYLOAD, 4'(i), seed + 8'(i)}));
         else qProt.push_back(32'({1'b1, 1'b0, tfr_pkg::KIND_PAYLOAD, 4'(i), seed + 8'(i)}));
      end
      #1;
      for (i = 0; i < 40 && busy === 1'b1; i++) @(posedge core_clk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #200us;
      badCount++;
      finalReport();
   end
   initial begin
      int i, p;
      logic [15:0] wa, wb;
      logic [31:0] expStat;
      sys_rst = 1'b1;
      clkEn = 1'b1;
      {regWr, regRd, serverFailIn, trailFailIn, trailDegradeIn, sendReq, rdSeen} = '0;
      {regAddr, regWrData, workingGroupData, protectionGroupData, ringSwitchWord, seed, pWord} = '0;
      {srcTiming, ttSrcIn} = '0;
      badCount = 0;
      nChecks = 0;
      void'($urandom(32'h3262));
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      regRead(`TFR_OFF_CTRL, 32'h0);
      regRead(`TFR_OFF_SLOT, 32'(`TFR_SLOT_RST));
      regRead(`TFR_OFF_STAT, 32'h0);
      regRead(`TFR_OFF_APS, 32'h0);
      regWrite(8'h10, 32'hffff_ffff);
      regRead(8'h10, 32'h0);
      // a write while the clock enable is low must be refused
      clkEn <= 1'b0;
      regWrite(`TFR_OFF_CTRL, 32'h1);
      clkEn <= 1'b1;
      regRead(`TFR_OFF_CTRL, 32'h0);
      // every slot mode appears in pass 0, random modes after
      for (p = 0; p < 3; p++) begin
         slotVal = p == 0 ? 16'he41b : 16'($urandom);
         regWrite(`TFR_OFF_SLOT, 32'(slotVal));
         ringSwitchWord <= 16'($urandom);
         srcBeat(tfr_pkg::KIND_K1, 4'h0);
         srcBeat(tfr_pkg::KIND_K2, 4'h0);
         for (i = 0; i < 16; i++) begin
            srcBeat(tfr_pkg::KIND_PTR, 4'(i));
            srcBeat(tfr_pkg::KIND_PAYLOAD, 4'(i));
         end
         srcBeat(tfr_pkg::KIND_OTHER, 4'h5);
         @(posedge core_clk);
         srcTiming <= '0;
         ttSrcIn <= '0;
      end
      regRead(`TFR_OFF_SLOT, 32'(slotVal));
      // status bits for every mix of fails and report enable
      for (i = 0; i < 16; i++) begin
         regWrite(`TFR_OFF_CTRL, 32'(i[3]));
         @(posedge core_clk);
         {serverFailIn, trailFailIn, trailDegradeIn} <= i[2:0];
         expStat = {28'h0, i[2], i[2] & i[3], i[0], i[1]};
         regRead(`TFR_OFF_STAT, expStat);
         @(negedge core_clk);
         check({28'h0, trailFailAction, failReportCause, serverDegradeAction, serverFailAction}, expStat);
      end
      // a word counts only after three identical frames in a row
      wa = 16'($urandom);
      wb = ~wa;
      sendFrame(wa);
      sendFrame(wa);
      regRead(`TFR_OFF_APS, 32'h0);
      sendFrame(wa);
      regRead(`TFR_OFF_APS, 32'(wa));
      sendFrame(wb);
      sendFrame(wb);
      sendFrame(wa);
      sendFrame(wb);
      sendFrame(wb);
      regRead(`TFR_OFF_APS, 32'(wa));
      check(32'(ringSwitchWordOut), 32'(wa));
      sendFrame(wb);
      regRead(`TFR_OFF_APS, 32'(wb));
      repeat (4) @(posedge core_clk);
      check(32'(qLine.size() + qWork.size() + qProt.size() + qTt.size() + qTs.size() + qRd.size()), 32'h0);
      check(32'(ringSwitchWordOut), 32'(wb));
      finalReport();
   end
endmodule // tfr_protection_test
`default_nettype wire
